/* File: logic/rcl_top.sv */
// Reset-cause recorder and configuration lock, APB slave.
// Assumes cause event inputs are asynchronous levels, one per reset source.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module rcl_top
	import rcl_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic shutoff_mode_cause,
	input wire logic watchdog_cause,
	input wire logic pin_cause,
	input wire logic power_on_cause,
	output logic [31:0] reset_control,
	output logic [31:0] reset_control_extension,
	output logic irq
);
	logic [RCL_NSRC-1:0] ev_async;
	logic [RCL_NSRC-1:0] ev_sync;
	logic [RCL_NSRC-1:0] ev_prev_r;
	logic [RCL_NSRC-1:0] ev_rise;
	logic [31:0] cause_r;
	logic [31:0] cause_set;
	logic locked_r;
	logic [RCL_NSRC-1:0] irq_stat_r;
	logic [RCL_NSRC-1:0] irq_mask_r;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic cause_clr;
	logic [31:0] rdata_nxt;

	assign ev_async = {shutoff_mode_cause, watchdog_cause, pin_cause, power_on_cause};

	rcl_sync #(.W(RCL_NSRC)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.async_in(ev_async),
		.sync_out(ev_sync)
	);

	// Edge detect after synchronisation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_prev_r <= '0;
		end else if (ce) begin
			ev_prev_r <= ev_sync;
		end
	end
	assign ev_rise = ev_sync & ~ev_prev_r;

	assign wr_en = ce & psel & penable & pwrite;
	assign rd_en = ce & psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_comb begin
		addr_ok = 1'b1;
		if (paddr == RCL_CTRL_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr == RCL_CAUSE_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr == RCL_CMD_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr == RCL_EXT_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr == RCL_LOCK_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr == RCL_IRQ_STAT_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr == RCL_IRQ_MASK_OFS) begin
			addr_ok = 1'b1;
		end else begin
			addr_ok = 1'b0;
		end
	end

	assign cause_clr = wr_en && paddr == RCL_CMD_OFS && pwdata[RCL_CLEAR_BIT];

	always_comb begin
		cause_set = '0;
		cause_set[RCL_SHUTOFF_BIT] = ev_rise[3];
		cause_set[RCL_WDOG_BIT] = ev_rise[2];
		cause_set[RCL_PIN_BIT] = ev_rise[1];
		cause_set[RCL_POR_BIT] = ev_rise[0];
	end

	// Sticky cause flags; a new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_r <= '0;
		end else if (ce) begin
			cause_r <= ((cause_clr ? 32'h0000_0000 : cause_r) | cause_set) & RCL_CAUSE_MASK;
		end
	end

	// Lock key: unlock code opens, anything else closes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			locked_r <= 1'b0;
		end else if (wr_en && paddr == RCL_LOCK_OFS) begin
			locked_r <= (pwdata[15:0] != RCL_UNLOCK_CODE);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_control <= RCL_CTRL_RST;
			reset_control_extension <= RCL_EXT_RST;
		end else if (wr_en && !locked_r) begin
			if (paddr == RCL_CTRL_OFS) begin
				reset_control <= pwdata & RCL_CTRL_WMASK;
			end else if (paddr == RCL_EXT_OFS) begin
				reset_control_extension <= pwdata;
			end
		end
	end

	// Interrupt status: set on event, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= RCL_IRQ_RST;
		end else if (ce) begin
			if (wr_en && paddr == RCL_IRQ_STAT_OFS) begin
				irq_stat_r <= (irq_stat_r & ~pwdata[RCL_NSRC-1:0]) | ev_rise;
			end else begin
				irq_stat_r <= irq_stat_r | ev_rise;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_r <= RCL_IRQ_RST;
		end else if (wr_en && paddr == RCL_IRQ_MASK_OFS) begin
			irq_mask_r <= pwdata[RCL_NSRC-1:0];
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (paddr == RCL_CTRL_OFS) begin
			rdata_nxt = reset_control;
		end else if (paddr == RCL_CAUSE_OFS) begin
			rdata_nxt = cause_r;
		end else if (paddr == RCL_EXT_OFS) begin
			rdata_nxt = reset_control_extension;
		end else if (paddr == RCL_LOCK_OFS) begin
			rdata_nxt[RCL_LOCKED_BIT] = locked_r;
		end else if (paddr == RCL_IRQ_STAT_OFS) begin
			rdata_nxt[RCL_NSRC-1:0] = irq_stat_r;
		end else if (paddr == RCL_IRQ_MASK_OFS) begin
			rdata_nxt[RCL_NSRC-1:0] = irq_mask_r;
		end
	end

	// Read data registered in the setup cycle so it is stable in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (ce && psel && !penable && !pwrite) begin
			prdata <= addr_ok ? rdata_nxt : 32'h0000_0000;
		end
	end

	AST_POR_SETS: assert property (@(posedge pclk) disable iff (!presetn)
		ce && ev_rise[0] |=> cause_r[RCL_POR_BIT])
		else $error("power-on cause not set");
	AST_PIN_SETS: assert property (@(posedge pclk) disable iff (!presetn)
		ce && ev_rise[1] |=> cause_r[RCL_PIN_BIT])
		else $error("pin cause not set");
	AST_WDOG_SETS: assert property (@(posedge pclk) disable iff (!presetn)
		ce && ev_rise[2] |=> cause_r[RCL_WDOG_BIT])
		else $error("watchdog cause not set");
	AST_SHUTOFF_SETS: assert property (@(posedge pclk) disable iff (!presetn)
		ce && ev_rise[3] |=> cause_r[RCL_SHUTOFF_BIT])
		else $error("shutoff cause not set");
	AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
		cause_r[RCL_POR_BIT] && !cause_clr |=> cause_r[RCL_POR_BIT])
		else $error("cause flag dropped without clear");
	AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		cause_clr && ev_rise == '0 |=> cause_r == 32'h0000_0000)
		else $error("cause clear failed");
	AST_LOCK_KEY: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == RCL_LOCK_OFS && pwdata[15:0] == RCL_UNLOCK_CODE |=> !locked_r)
		else $error("unlock code did not unlock");
	AST_LOCK_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		locked_r && wr_en && paddr == RCL_CTRL_OFS |=> $stable(reset_control))
		else $error("locked control register changed");
	AST_LOCK_READ: assert property (@(posedge pclk) disable iff (!presetn)
		ce && psel && !penable && !pwrite && paddr == RCL_LOCK_OFS
		##1 !(wr_en && paddr == RCL_LOCK_OFS) |-> prdata[RCL_LOCKED_BIT] == locked_r)
		else $error("lock read mismatch");

	// Steps of a register transfer used by the checks below
	sequence s_rd_setup;
		ce && psel && !penable && !pwrite;
	endsequence
	sequence s_wr_lock_key;
		wr_en && paddr == RCL_LOCK_OFS && pwdata[15:0] != RCL_UNLOCK_CODE;
	endsequence
	sequence s_wr_ctrl_open;
		!locked_r && wr_en && paddr == RCL_CTRL_OFS;
	endsequence

	// Lock behaviour
	AST_LOCK_SET: assert property (@(posedge pclk) disable iff (!presetn)
		s_wr_lock_key |=> locked_r)
		else $error("non-unlock key did not lock");
	AST_EXT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		locked_r && wr_en && paddr == RCL_EXT_OFS |=> $stable(reset_control_extension))
		else $error("locked extension register changed");
	AST_CTRL_OPEN: assert property (@(posedge pclk) disable iff (!presetn)
		s_wr_ctrl_open |=> reset_control == ($past(pwdata) & RCL_CTRL_WMASK))
		else $error("unlocked control write lost");
	AST_LOCK_RD_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup ##0 paddr == RCL_LOCK_OFS |=> prdata[31:1] == 31'h0000_0000)
		else $error("lock read shows reserved bits");

	// Cause flags
	AST_NO_SELF_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		!cause_clr |=> (cause_r & $past(cause_r)) == $past(cause_r))
		else $error("cause flag cleared by hardware");
	AST_CAUSE_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
		(cause_r & ~RCL_CAUSE_MASK) == 32'h0000_0000)
		else $error("reserved cause bit set");
	AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
		cause_clr && ev_rise[0] |=> cause_r[RCL_POR_BIT])
		else $error("event lost against clear");
	AST_CMD_READ: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup ##0 paddr == RCL_CMD_OFS |=> prdata == 32'h0000_0000)
		else $error("command register read not zero");
	AST_RD_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup ##0 paddr == RCL_CAUSE_OFS |=> prdata == $past(cause_r))
		else $error("cause read mismatch");

	// Interrupt status and clock enable
	AST_IRQ_SET: assert property (@(posedge pclk) disable iff (!presetn)
		ce && ev_rise != '0 |=> (irq_stat_r & $past(ev_rise)) == $past(ev_rise))
		else $error("event did not set interrupt status");
	AST_CE_FREEZE: assert property (@(posedge pclk) disable iff (!presetn)
		!ce |=> $stable(cause_r) && $stable(locked_r) && $stable(irq_stat_r)
		&& $stable(reset_control))
		else $error("state changed while clock enable low");
endmodule // rcl_top

/* File: inc/rcl_pkg.sv */
// Package for the reset-cause recorder and configuration lock.
// Assumes a 32-bit APB slave with byte offsets as listed.
package rcl_pkg;
	localparam logic [11:0] RCL_CTRL_OFS = 12'h000;
	localparam logic [11:0] RCL_CAUSE_OFS = 12'h004;
	localparam logic [11:0] RCL_CMD_OFS = 12'h008;
	localparam logic [11:0] RCL_EXT_OFS = 12'h00C;
	localparam logic [11:0] RCL_LOCK_OFS = 12'h010;
	localparam logic [11:0] RCL_IRQ_STAT_OFS = 12'h020;
	localparam logic [11:0] RCL_IRQ_MASK_OFS = 12'h024;
	localparam int RCL_SHUTOFF_BIT = 16;
	localparam int RCL_WDOG_BIT = 11;
	localparam int RCL_PIN_BIT = 8;
	localparam int RCL_POR_BIT = 0;
	localparam int RCL_CLEAR_BIT = 0;
	localparam int RCL_LOCKED_BIT = 0;
	localparam int RCL_NSRC = 4;
	localparam logic [15:0] RCL_UNLOCK_CODE = 16'hE084;
	localparam logic [31:0] RCL_CTRL_RST = 32'h0000_0204;
	localparam logic [31:0] RCL_CTRL_WMASK = 32'h0300_7777;
	localparam logic [31:0] RCL_EXT_RST = 32'h0000_0000;
	localparam logic [31:0] RCL_CAUSE_MASK = 32'h0001_0901;
	localparam logic [RCL_NSRC-1:0] RCL_IRQ_RST = 4'h0;
endpackage

/* File: logic/rcl_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes inputs come from outside the pclk domain.
`timescale 1ns/1ns
module rcl_sync #(
	parameter int W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			sync_out <= '0;
		end else if (ce) begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // rcl_sync

/* File: tb/rcl_top_tb.sv */
// Testbench for the reset-cause recorder and configuration lock.
// Assumes rcl_top answers APB transfers itself and pclk runs at 250 MHz.
`timescale 1ns/1ns
module rcl_top_tb;
	import rcl_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rctl, rext, q, v, ctl_exp;
	logic pready, pslverr, irq;
	logic [3:0] ev = 4'h0;
	logic ce = 1'b1;
	logic [15:0] key;
	int errors = 0;
	int num_checks = 0;
	always #2 pclk = ~pclk;
	rcl_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.shutoff_mode_cause(ev[3]), .watchdog_cause(ev[2]), .pin_cause(ev[1]),
		.power_on_cause(ev[0]), .reset_control(rctl),
		.reset_control_extension(rext), .irq(irq));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		chk("pready", {31'h0, pready}, 32'h1);
		chk("pslverr", {31'h0, pslverr}, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask
	task automatic irqchk(input logic e);
		@(negedge pclk);
		chk("irq", {31'h0, irq}, {31'h0, e});
	endtask
	function automatic logic [31:0] cause_of(input logic [3:0] m);
		cause_of = 32'h0;
		cause_of[RCL_SHUTOFF_BIT] = m[3];
		cause_of[RCL_WDOG_BIT] = m[2];
		cause_of[RCL_PIN_BIT] = m[1];
		cause_of[RCL_POR_BIT] = m[0];
	endfunction
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#80000;
		errors++;
		tally_and_finish();
	end
	initial begin
		v = $urandom(78);
		ctl_exp = RCL_CTRL_RST;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("ctrl_rst", RCL_CTRL_OFS, RCL_CTRL_RST);
		rdchk("ext_rst", RCL_EXT_OFS, RCL_EXT_RST);
		rdchk("lock_rst", RCL_LOCK_OFS, 32'h0);
		rdchk("cause_rst", RCL_CAUSE_OFS, 32'h0);
		rdchk("unmapped", 12'h03C, 32'h0);
		// Single sources first, then a random mix, then all at once
		for (int i = 0; i < 6; i++) begin
			v = (i < 4) ? (32'h1 << i) : ((i == 4) ? $urandom : 32'hF);
			@(posedge pclk);
			ev <= v[3:0];
			repeat (2) @(posedge pclk);
			ev <= 4'h0;
			repeat (5) @(posedge pclk);
			rdchk("cause", RCL_CAUSE_OFS, cause_of(v[3:0]));
			rdchk("irq_stat", RCL_IRQ_STAT_OFS, {28'h0, v[3:0]});
			irqchk(1'b0);
			wr(RCL_IRQ_MASK_OFS, {28'h0, v[3:0]});
			irqchk(|v[3:0]);
			wr(RCL_CMD_OFS, 32'h1);
			rdchk("cause_clr", RCL_CAUSE_OFS, 32'h0);
			rdchk("cmd_rd", RCL_CMD_OFS, 32'h0);
			wr(RCL_IRQ_STAT_OFS, 32'hF);
			irqchk(1'b0);
			wr(RCL_IRQ_MASK_OFS, 32'h0);
		end
		// An event pulse while the block is frozen must leave no trace
		@(posedge pclk);
		ce <= 1'b0;
		ev <= 4'h1;
		repeat (4) @(posedge pclk);
		ev <= 4'h0;
		repeat (4) @(posedge pclk);
		ce <= 1'b1;
		repeat (5) @(posedge pclk);
		rdchk("cause_frozen", RCL_CAUSE_OFS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			key = $urandom;
			if (i == 0) key = RCL_UNLOCK_CODE ^ 16'h0001;
			if (i == 1 || key == RCL_UNLOCK_CODE) key = 16'h0000;
			wr(RCL_LOCK_OFS, {16'h0, key});
			apb(1'b0, RCL_LOCK_OFS, 32'h0);
			chk("locked", {31'h0, q[RCL_LOCKED_BIT]}, 32'h1);
			v = $urandom & RCL_CTRL_WMASK;
			wr(RCL_CTRL_OFS, v);
			wr(RCL_EXT_OFS, 32'h0);
			rdchk("ctrl_kept", RCL_CTRL_OFS, ctl_exp);
			chk("ctrl_port", rctl, ctl_exp);
			wr(RCL_LOCK_OFS, {16'h0, RCL_UNLOCK_CODE});
			apb(1'b0, RCL_LOCK_OFS, 32'h0);
			chk("unlocked", {31'h0, q[RCL_LOCKED_BIT]}, 32'h0);
			wr(RCL_CTRL_OFS, v);
			ctl_exp = v;
			rdchk("ctrl_new", RCL_CTRL_OFS, ctl_exp);
			chk("ctrl_port", rctl, ctl_exp);
			chk("ext_port", rext, RCL_EXT_RST);
		end
		tally_and_finish();
	end
endmodule // rcl_top_tb
